/* pkg/rpc_pkg.sv */
// Purpose: constants for the reset and phy power controller
// Assumes: 40 MHz ref_clk
// Notes: register offsets are word indices on the plain register port
package rpc_pkg;
  localparam int unsigned ClkMhz = 40;
  // times in their own units
  localparam int unsigned PorTimeUs = 22000;
  localparam int unsigned SoftRstTimeUs = 2;
  localparam int unsigned PhyRstTimeUs = 100;
  localparam int unsigned WakeTimeUs = 1000;
  localparam int unsigned EepProbeTimeUs = 50;
  localparam int unsigned PorCycles = PorTimeUs * ClkMhz;
  localparam int unsigned SoftRstCycles = SoftRstTimeUs * ClkMhz;
  localparam int unsigned PhyRstCycles = PhyRstTimeUs * ClkMhz;
  localparam int unsigned WakeCycles = WakeTimeUs * ClkMhz;
  localparam int unsigned EepProbeCycles = EepProbeTimeUs * ClkMhz;
  localparam int CntW = 20;
  localparam int AddrW = 4;
  // register offsets
  localparam logic [3:0] RegHwCfg = 4'h0;
  localparam logic [3:0] RegPmCtrl = 4'h1;
  localparam logic [3:0] RegWakeTest = 4'h2;
  localparam logic [3:0] RegEepCmd = 4'h3;
  localparam logic [3:0] RegPhyBasic = 4'h4;
  localparam logic [3:0] RegPhyStatus = 4'h5;
  localparam logic [3:0] RegPhyMode = 4'h6;
  localparam logic [3:0] RegPhyIntSrc = 4'h7;
  localparam logic [3:0] RegPhyIntMask = 4'h8;
  localparam logic [3:0] RegResetSts = 4'h9;
  // field positions
  localparam int BitSoftRst = 0;
  localparam int BitReady = 0;
  localparam int BitPhyRst = 10;
  localparam int BitPmModeLo = 12;
  localparam int BitBasicRst = 15;
  localparam int BitBasicPwrDn = 11;
  localparam int BitLinkUp = 2;
  localparam int BitEdPwrDn = 13;
  localparam int BitEnergyNow = 1;
  localparam int BitEnergyOn = 1;
  localparam int BitEepBusy = 31;
  // reset values
  localparam logic [1:0] PmModeD0 = 2'h0;
  localparam logic [31:0] ZeroWord = 32'h0;
endpackage

/* logic/rpc_timer.sv */
// Purpose: one-shot cycle timer used by each reset stretch
// Assumes: same clock as caller
// Notes: start reloads the count, done pulses once at expiry
`timescale 1ns/1ps
module rpc_timer (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [rpc_pkg::CntW-1:0] load,
  output logic busy,
  output logic done
);
  import rpc_pkg::*;
  logic [CntW-1:0] cnt_q, cnt_d;
  logic busy_q, busy_d, done_q, done_d;
  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (start) begin
      cnt_d = load;
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (cnt_q <= CntW'(1)) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
      cnt_d = cnt_q - CntW'(1);
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end
  assign busy = busy_q;
  assign done = done_q;
endmodule

/* logic/rpc_reset_ctrl.sv */
// Purpose: chip reset sequencer with phy energy-detect power-down
// Assumes: 40 MHz ref_clk, plain register port, read data one cycle late
// Notes: long counts are parameters so simulation can shorten them
// How it works
// - 17.13 set enables energy-detect power-down
// - no energy: phy off, transmit off
// - energy returns: power up, set energy flag
// - enabled energy flag raises host interrupt
// - wake-causing packets may be dropped
// - 17.13 clear keeps phy powered unless basic bit 11 set
// - pin/power reset hits every domain, reloads
// - soft reset spares pll, phy, straps, exempt
// - pm control bit 10 resets phy, clears
// - basic control bit 15 resets phy, self-clears
// - power-on timer holds reset, ready low
// - reset pin low: full reset, ready low
// - reset pin idles inactive when unconnected
// - wake test write sets ready within 2ms
// - config bit 0 soft reset, self-clears ~2us
// - eeprom probe after full/soft reset, busy
// - after phy reset hold tx until link
// - basic bit 11 powers down; clear resets
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module rpc_reset_ctrl #(
  parameter logic [19:0] POR_CYCLES = 20'(rpc_pkg::PorCycles),
  parameter logic [19:0] WAKE_CYCLES = 20'(rpc_pkg::WakeCycles)
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hwResetInN,
  input wire logic [rpc_pkg::AddrW-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [31:0] regRdData,
  input wire logic linePulse,
  input wire logic linkUp,
  input wire logic txPending,
  input wire logic [1:0] pmModeReq,
  output logic pllRst,
  output logic hostBusRst,
  output logic exemptRst,
  output logic miiRst,
  output logic macRst,
  output logic phyRst,
  output logic phyPowered,
  output logic txAllowed,
  output logic strapLatch,
  output logic eepBusy,
  output logic phyIrq,
  output logic ready
);
  import rpc_pkg::*;
  // pin sync; the pad pull-up keeps an open pin at 1
  logic pinS1_q, pinS2_q;
  always_ff @(posedge ref_clk) begin
    pinS1_q <= hwResetInN;
    pinS2_q <= pinS1_q;
  end
  // pin low counts as reset until synchronised high
  logic pinLow;
  assign pinLow = ~pinS2_q;
  logic fullTrig, porBusy, porDone;
  logic softTrig, softBusy, softDone;
  logic phyTrig, phyBusy, phyDone;
  logic wakeTrig, wakeBusy, wakeDone;
  logic eepTrig, eepBusyT, eepDone;
  logic porInit_q;
  always_ff @(posedge ref_clk) begin
    if (reset) porInit_q <= 1'b1;
    else porInit_q <= 1'b0;
  end
  // power-on or pin reset restarts the long stretch
  assign fullTrig = porInit_q | pinLow;
  rpc_timer u_por (.ref_clk(ref_clk), .reset(1'b0), .start(fullTrig),
    .load(POR_CYCLES), .busy(porBusy), .done(porDone));
  rpc_timer u_soft (.ref_clk(ref_clk), .reset(reset), .start(softTrig),
    .load(20'(SoftRstCycles)), .busy(softBusy), .done(softDone));
  rpc_timer u_phy (.ref_clk(ref_clk), .reset(reset), .start(phyTrig),
    .load(20'(PhyRstCycles)), .busy(phyBusy), .done(phyDone));
  rpc_timer u_wake (.ref_clk(ref_clk), .reset(reset), .start(wakeTrig),
    .load(WAKE_CYCLES), .busy(wakeBusy), .done(wakeDone));
  rpc_timer u_eep (.ref_clk(ref_clk), .reset(reset), .start(eepTrig),
    .load(20'(EepProbeCycles)), .busy(eepBusyT), .done(eepDone));
  logic fullRst;
  assign fullRst = fullTrig | porBusy;
  // software state
  logic softBit_q, softBit_d, phyRstBit_q, phyRstBit_d;
  logic basicRst_q, basicRst_d, pwrDn_q, pwrDn_d;
  logic edEn_q, edEn_d, enFlag_q, enFlag_d, enMask_q, enMask_d;
  logic asleep_q, asleep_d, lastFull_q, txHold_q, txHold_d;
  logic [31:0] rd_d, rd_q;
  logic pwrUpRst, wrHit;
  logic [3:0] wa;
  assign wa = regAddr;
  // wake write is the only write honoured while asleep
  assign wrHit = regWrStb & (~asleep_q | (wa == RegWakeTest));
  assign softTrig = wrHit & (wa == RegHwCfg) & regWrData[BitSoftRst];
  // clearing general power-down restarts the phy
  assign pwrUpRst = wrHit & (wa == RegPhyBasic) & pwrDn_q
    & ~regWrData[BitBasicPwrDn];
  assign phyTrig = (wrHit & (wa == RegPmCtrl) & regWrData[BitPhyRst])
    | (wrHit & (wa == RegPhyBasic) & regWrData[BitBasicRst])
    | pwrUpRst;
  assign wakeTrig = asleep_q & regWrStb & (wa == RegWakeTest);
  // probe after full or soft reset ends
  assign eepTrig = (lastFull_q & ~fullRst) | softDone;
  always_ff @(posedge ref_clk) begin
    lastFull_q <= fullRst;
  end
  always_comb begin
    softBit_d = softBusy | softTrig ? 1'b1 : 1'b0;
    phyRstBit_d = phyRstBit_q;
    basicRst_d = basicRst_q;
    pwrDn_d = pwrDn_q;
    edEn_d = edEn_q;
    enMask_d = enMask_q;
    enFlag_d = enFlag_q;
    asleep_d = asleep_q;
    txHold_d = txHold_q;
    if (wrHit && wa == RegPmCtrl && regWrData[BitPhyRst]) phyRstBit_d = 1'b1;
    if (wrHit && wa == RegPhyBasic) begin
      if (regWrData[BitBasicRst]) basicRst_d = 1'b1;
      pwrDn_d = regWrData[BitBasicPwrDn];
    end
    if (phyDone) begin
      phyRstBit_d = 1'b0;
      basicRst_d = 1'b0;
    end
    if (wrHit && wa == RegPhyMode) edEn_d = regWrData[BitEdPwrDn];
    if (wrHit && wa == RegPhyIntMask) enMask_d = regWrData[BitEnergyOn];
    // set beats clear in the same cycle
    if (wrHit && wa == RegPhyIntSrc && regWrData[BitEnergyOn])
      enFlag_d = 1'b0;
    if (edEn_q && linePulse && !phyPowered) enFlag_d = 1'b1;
    if (wrHit && wa == RegPmCtrl && regWrData[13:12] != PmModeD0)
      asleep_d = 1'b1;
    if (pmModeReq != PmModeD0) asleep_d = 1'b1;
    if (wakeDone) asleep_d = 1'b0;
    if (phyTrig) txHold_d = 1'b1;
    else if (linkUp) txHold_d = 1'b0;
    rd_d = ZeroWord;
    if (regRdStb) begin
      unique case (wa)
        RegHwCfg: rd_d[BitSoftRst] = softBit_q;
        RegPmCtrl: begin
          rd_d[BitReady] = ready;
          rd_d[BitPhyRst] = phyRstBit_q;
        end
        RegEepCmd: rd_d[BitEepBusy] = eepBusy;
        RegPhyBasic: begin
          rd_d[BitBasicRst] = basicRst_q;
          rd_d[BitBasicPwrDn] = pwrDn_q;
        end
        RegPhyStatus: rd_d[BitLinkUp] = linkUp;
        RegPhyMode: begin
          rd_d[BitEdPwrDn] = edEn_q;
          rd_d[BitEnergyNow] = linePulse;
        end
        RegPhyIntSrc: rd_d[BitEnergyOn] = enFlag_q;
        RegPhyIntMask: rd_d[BitEnergyOn] = enMask_q;
        RegResetSts: rd_d[5:0] = {softBusy, phyBusy, wakeBusy, eepBusyT,
          porBusy, asleep_q};
        default: rd_d = ZeroWord;
      endcase
    end
    if (asleep_q && wa != RegPmCtrl) rd_d = ZeroWord;
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      softBit_q <= 1'b0;
      phyRstBit_q <= 1'b0;
      basicRst_q <= 1'b0;
      pwrDn_q <= 1'b0;
      edEn_q <= 1'b0;
      enMask_q <= 1'b0;
      enFlag_q <= 1'b0;
      asleep_q <= 1'b0;
      txHold_q <= 1'b1;
      rd_q <= ZeroWord;
    end else if (fullRst) begin
      // pin and power reset clear exempt state too
      softBit_q <= 1'b0;
      phyRstBit_q <= 1'b0;
      basicRst_q <= 1'b0;
      pwrDn_q <= 1'b0;
      edEn_q <= 1'b0;
      enMask_q <= 1'b0;
      enFlag_q <= 1'b0;
      asleep_q <= 1'b0;
      txHold_q <= 1'b1;
      rd_q <= rd_d;
    end else begin
      softBit_q <= softBit_d;
      phyRstBit_q <= phyRstBit_d;
      basicRst_q <= basicRst_d;
      pwrDn_q <= pwrDn_d;
      edEn_q <= edEn_d;
      enMask_q <= enMask_d;
      enFlag_q <= enFlag_d;
      asleep_q <= asleep_d;
      txHold_q <= txHold_d;
      rd_q <= rd_d;
    end
  end
  assign regRdData = rd_q;
  // energy gating: phy sleeps with no line energy while 17.13 set, or on basic bit 11 power-down
  logic pwr_d, pwr_q;
  always_comb begin
    pwr_d = 1'b1;
    if (edEn_q && !linePulse) pwr_d = 1'b0;
    if (pwrDn_q) pwr_d = 1'b0;
  end
  // outputs, all registered
  logic [11:0] out_d, out_q;
  always_comb begin
    out_d[0] = fullRst;
    out_d[1] = fullRst | softBusy | softTrig;
    out_d[2] = fullRst;
    out_d[3] = fullRst | softBusy | softTrig;
    out_d[4] = fullRst | softBusy | softTrig;
    out_d[5] = fullRst | phyBusy | phyTrig;
    out_d[6] = pwr_d & ~fullRst; // state kept, no reset on wake
    // queued frames wait for link; wake frames may drop
    out_d[7] = ~txHold_q & linkUp & txPending & pwr_q;
    out_d[8] = lastFull_q & ~fullRst; // straps latched at release
    out_d[9] = fullRst | eepBusyT | eepTrig;
    out_d[10] = enFlag_q & enMask_q;
    // ready low through full or soft reset or sleep, not phy reset
    out_d[11] = ~(fullRst | softBusy | softTrig | asleep_q);
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      // resets high, phy unpowered, ready low while held
      out_q <= 12'h03f;
      pwr_q <= 1'b0;
    end else begin
      out_q <= out_d;
      pwr_q <= pwr_d;
    end
  end
  assign pllRst = out_q[0];
  assign hostBusRst = out_q[1];
  assign exemptRst = out_q[2];
  assign miiRst = out_q[3];
  assign macRst = out_q[4];
  assign phyRst = out_q[5];
  assign phyPowered = out_q[6];
  assign txAllowed = out_q[7];
  assign strapLatch = out_q[8];
  assign eepBusy = out_q[9];
  assign phyIrq = out_q[10];
  assign ready = out_q[11];
endmodule

/* dv/rpc_reset_checker.sv */
// Purpose: port-level assertions for the reset controller
// Assumes: bench shortens POR_CYCLES to 50, WAKE_CYCLES to 20
// Notes: bound into rpc_reset_ctrl from the bench top file
`timescale 1ns/1ps
module rpc_reset_checker
  import rpc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hwResetInN,
  input wire logic [rpc_pkg::AddrW-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStb,
  input wire logic linkUp,
  input wire logic [1:0] pmModeReq,
  input wire logic pllRst,
  input wire logic hostBusRst,
  input wire logic macRst,
  input wire logic phyRst,
  input wire logic txAllowed,
  input wire logic ready
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_por_ready_low: assert property ($fell(reset) |-> !ready [*8])
    else $error("ready rose during power-on stretch");
  a_pin_full_rst: assert property ($fell(hwResetInN) |-> ##[1:4]
    (pllRst && phyRst && hostBusRst && macRst))
    else $error("pin reset missed a domain");
  a_soft_spares: assert property ((regWrStb && regAddr == RegHwCfg
    && regWrData[BitSoftRst] && ready)
    |-> ##2 (hostBusRst && macRst && !pllRst && !phyRst))
    else $error("soft reset domains wrong");
  a_rst_not_ready: assert property ((hostBusRst || pllRst) |-> !ready)
    else $error("ready high during reset");
  a_phy_only: assert property ((regWrStb && regAddr == RegPmCtrl
    && regWrData[BitPhyRst] && ready)
    |-> ##[1:3] (phyRst && !macRst && !pllRst))
    else $error("pm control phy reset wrong");
  a_basic_rst: assert property ((regWrStb && regAddr == RegPhyBasic
    && regWrData[BitBasicRst] && ready) |-> ##[1:3] (phyRst && !hostBusRst))
    else $error("basic control phy reset wrong");
  a_tx_link: assert property ($rose(txAllowed) |-> $past(linkUp))
    else $error("transmit allowed without link");
  a_wake_ready: assert property ((regWrStb && regAddr == RegWakeTest
    && !ready && !hostBusRst && !pllRst && pmModeReq == 2'h0)
    |-> ##[1:40] ready)
    else $error("ready late after wake write");
endmodule

/* dv/rpc_line_model.sv */
// Purpose: far side: reset pin with pull-up, line energy and link
// Assumes: bench requests pin and line events
// Notes: link only reported while energy is present
`timescale 1ns/1ps
module rpc_line_model (
  input wire logic pinLowReq,
  input wire logic energyReq,
  input wire logic linkReq,
  output logic hwResetInN,
  output logic linePulse,
  output logic linkUp
);
  // undriven request floats, pull-up keeps the pin inactive
  assign hwResetInN = (pinLowReq === 1'b1) ? 1'b0 : 1'b1;
  assign linePulse = energyReq;
  assign linkUp = linkReq && energyReq;
endmodule

/* dv/tb.sv */
// Purpose: self-checking bench for rpc_reset_ctrl
// Assumes: shortened power-on and wake counts
// Notes: reads are checked against a queue by a monitor
`timescale 1ns/1ps
module tb;
  import rpc_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic pinLowReq = 1'b0, energyReq = 1'b0, linkReq = 1'b0;
  logic regWrStb = 1'b0, regRdStb = 1'b0, txPending = 1'b0, rdPend = 1'b0;
  logic [AddrW-1:0] regAddr = '0;
  logic [31:0] regWrData = '0, regRdData, lfsr = 32'h45be;
  logic [1:0] pmModeReq = 2'h0;
  logic hwResetInN, linePulse, linkUp, pllRst, hostBusRst, exemptRst;
  logic miiRst, macRst, phyRst, phyPowered, txAllowed, strapLatch;
  logic eepBusy, phyIrq, ready;
  logic [31:0] expQ[$], mskQ[$];
  int mismatches = 0, tests_run = 0, straps = 0;
  always #12.5 ref_clk = ~ref_clk;
  rpc_line_model i_line (.pinLowReq, .energyReq, .linkReq, .hwResetInN,
    .linePulse, .linkUp);
  rpc_reset_ctrl #(.POR_CYCLES(20'd50), .WAKE_CYCLES(20'd20)) i_dut (
    .ref_clk, .reset, .hwResetInN, .regAddr, .regWrData, .regWrStb,
    .regRdStb, .regRdData, .linePulse, .linkUp, .txPending, .pmModeReq,
    .pllRst, .hostBusRst, .exemptRst, .miiRst, .macRst, .phyRst,
    .phyPowered, .txAllowed, .strapLatch, .eepBusy, .phyIrq, .ready);
  function automatic logic [31:0] nextRand();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic logic pick(input int k);
    case (k)
      0: return ready;
      1: return eepBusy;
      2: return phyRst;
      default: return phyPowered;
    endcase
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge ref_clk);
    regWrStb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    @(posedge ref_clk);
    expQ.push_back(e & m);
    mskQ.push_back(m);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge ref_clk);
    regRdStb <= 1'b0;
  endtask
  // bounded poll so a stuck flag ends as a mismatch, not a hang
  task automatic waitFor(input int k, input logic v, input int lim);
    int i;
    for (i = 0; i < lim && pick(k) !== v; i++) @(posedge ref_clk);
    chk("flag wait", 32'(v), 32'(pick(k)));
  endtask
  always @(posedge ref_clk) begin
    if (rdPend) chk("read", expQ.pop_front(), regRdData & mskQ.pop_front());
    rdPend <= regRdStb;
  end
  always @(posedge ref_clk) begin
    if (strapLatch === 1'b1) straps++;
  end
  initial begin
    #1500000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    int k;
    cyc(4);
    reset <= 1'b0;
    waitFor(0, 1'b1, 200);
    rd(RegPmCtrl, 32'h1, 32'h1);
    wr(4'hf, nextRand());
    rd(4'hf, 32'h0, 32'hffffffff);
    wr(RegHwCfg, 32'h1);
    waitFor(0, 1'b0, 5);
    chk("exempt", 32'h0, 32'(exemptRst));
    chk("mii", 32'h1, 32'(miiRst));
    waitFor(0, 1'b1, 300);
    rd(RegEepCmd, 32'h80000000, 32'h80000000);
    rd(RegHwCfg, 32'h0, 32'h1);
    waitFor(1, 1'b0, 2500);
    rd(RegEepCmd, 32'h0, 32'h80000000);
    for (k = 0; k < 2; k++) begin
      wr(k ? RegPhyBasic : RegPmCtrl, k ? 32'h8000 : 32'h400);
      rd(k ? RegPhyBasic : RegPmCtrl, 32'hffffffff, k ? 32'h8000 : 32'h400);
      waitFor(2, 1'b0, 5000);
      cyc(2);
      rd(k ? RegPhyBasic : RegPmCtrl, 32'h0, k ? 32'h8000 : 32'h400);
    end
    wr(RegPhyIntMask, 32'h2);
    wr(RegPhyMode, 32'h2000);
    waitFor(3, 1'b0, 20);
    energyReq <= 1'b1;
    waitFor(3, 1'b1, 5000);
    rd(RegPhyIntSrc, 32'h2, 32'h2);
    chk("irq", 32'h1, 32'(phyIrq));
    wr(RegPhyIntSrc, 32'h2);
    wr(RegPhyMode, 32'h0);
    energyReq <= 1'b0;
    txPending <= 1'b1;
    cyc(10);
    chk("powered", 32'h1, 32'(phyPowered));
    chk("tx", 32'h0, 32'(txAllowed));
    energyReq <= 1'b1;
    linkReq <= 1'b1;
    cyc(6);
    chk("tx", 32'h1, 32'(txAllowed));
    wr(RegPhyBasic, 32'h800);
    waitFor(3, 1'b0, 5);
    wr(RegPhyBasic, 32'h0);
    waitFor(2, 1'b1, 5);
    pmModeReq <= {1'b1, lfsr[0]};
    waitFor(0, 1'b0, 20);
    rd(RegHwCfg, 32'h0, 32'hffffffff);
    pmModeReq <= 2'h0;
    wr(RegWakeTest, nextRand());
    waitFor(0, 1'b1, 40);
    pinLowReq <= 1'b1;
    cyc(6);
    chk("pll", 32'h1, 32'(pllRst));
    chk("exempt", 32'h1, 32'(exemptRst));
    chk("mii", 32'h1, 32'(miiRst));
    pinLowReq <= 1'b0;
    waitFor(0, 1'b1, 300);
    cyc(2);
    chk("straps", 32'h2, 32'(straps));
    report_and_stop();
  end
endmodule
bind rpc_reset_ctrl rpc_reset_checker i_chk (.ref_clk, .reset, .hwResetInN,
  .regAddr, .regWrData, .regWrStb, .linkUp, .pmModeReq, .pllRst,
  .hostBusRst, .macRst, .phyRst, .txAllowed, .ready);
